// >>> rtl/sram_ctl_pkg.sv
// Shared constants and types for the synchronous burst SRAM control block
package sram_ctl_pkg;
  // Geometry: 9-bit lanes, four lanes to the word, 256K words
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 18;
  // Burst counter width and burst length
  localparam int BURST_W = 2;
  localparam int BURST_LEN = 4;
  // Clock and sleep timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int SLEEP_RECOVERY_NS = 100;
  localparam int SLEEP_RECOVERY_CYCLES = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CNT_W = 8;
  // Kind of burst in progress
  typedef enum logic [1:0] {
    BURST_NONE = 2'b00,
    BURST_READ = 2'b01,
    BURST_WRITE = 2'b10
  } burst_kind_t;
  // Sleep control states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_ENTER = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_RECOVER = 2'b11
  } pwr_state_t;
endpackage : sram_ctl_pkg

// >>> rtl/burst_addr_gen.sv
// Two-bit burst address generator, linear or interleaved order
`timescale 1ns/1ps
module burst_addr_gen #(
  parameter int BW = sram_ctl_pkg::BURST_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic load,
  input wire logic advance,
  input wire logic [BW-1:0] start_bits,
  input wire logic linear_order_n,
  output logic [BW-1:0] low_bits
);
  logic [BW-1:0] start_q;
  logic [BW-1:0] step_q;
  logic [BW-1:0] step_d;

  // The order logic only serves a two-bit counter
  if (BW != sram_ctl_pkg::BURST_W) begin : g_bad_bw
    $error("burst_addr_gen: only a 2-bit counter is supported");
  end

  // Step wraps naturally, so the fifth access returns to the start
  assign step_d = step_q + BW'(1);

  // Low address bits of the access taken at this edge
  always_comb begin
    if (load) begin
      low_bits = start_bits;
    end else if (linear_order_n) begin
      low_bits = start_q ^ step_d;
    end else begin
      low_bits = start_q + step_d;
    end
  end

  // Counter loads on a begin cycle and steps on each continue
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      start_q <= '0;
      step_q <= '0;
    end else if (run && load) begin
      start_q <= start_bits;
      step_q <= '0;
    end else if (run && advance) begin
      step_q <= step_d;
    end
  end

  a_step_loaded: assert property (@(posedge core_clk) disable iff (!nrst)
    run && load |=> step_q == '0) else $error("burst step not cleared on load");
  a_step_wraps: assert property (@(posedge core_clk) disable iff (!nrst)
    run && advance && !load && step_q == '1 |=> step_q == '0) else $error("burst step did not wrap");
endmodule : burst_addr_gen

// >>> rtl/lane_mem.sv
// Word array with per-lane write enables and combinational read
`timescale 1ns/1ps
module lane_mem #(
  parameter int AW = sram_ctl_pkg::ADDR_W,
  parameter int LW = sram_ctl_pkg::LANE_W,
  parameter int NL = sram_ctl_pkg::LANES
) (
  input wire logic core_clk,
  input wire logic [NL-1:0] wr_lanes,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [NL*LW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [NL*LW-1:0] rd_data
);
  logic [NL*LW-1:0] mem [0:(1<<AW)-1];

  // Guard against an array too small to burst or too large to hold
  if (AW < 2 || AW > 24) begin : g_bad_aw
    $error("lane_mem: address width out of range");
  end

  // One writer per lane, so partial words keep their other lanes
  for (genvar g = 0; g < NL; g++) begin : g_lane
    always_ff @(posedge core_clk) begin
      if (wr_lanes[g]) begin
        mem[wr_addr][g*LW +: LW] <= wr_data[g*LW +: LW];
      end
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : lane_mem

// >>> rtl/sync_burst_sram_control.sv
// Command decode, burst, data pipeline and sleep control of a no-turnaround burst SRAM
`timescale 1ns/1ps
// How it works
// - Load, selects active, store high: read begins
// - Load, selects active, store low, not recovering: write begins
// - Advance high continues burst, selects ignored
// - Store low, no lanes: nothing written
// - Load with any select inactive: deselect
// - Output enable high hides read begin data
// - Output enable high: dummy read still advances
// - Drivers off automatically during writes
// - Clock hold freezes state, address, drive
// - Two-bit counter wraps after four accesses
// - Linear order adds one modulo four
// - Interleaved order XORs the step count
// - Strap pins default to pipeline, low drive
// - Sleep two cycles after request; timed recovery
// - Asleep: burst state frozen, inputs ignored, outputs off
// - Output enable unclocked; sleep request sampled on every edge, held or not
// - Outputs off from the first reset edge
// - Pipeline read data after second edge
// - Pipeline write data taken third edge
// - Flow-through read one cycle shorter
// - Flow-through write data taken second edge
module sync_burst_sram_control #(
  parameter int AW = sram_ctl_pkg::ADDR_W,
  parameter int NL = sram_ctl_pkg::LANES,
  parameter int RECOVERY_CYCLES = sram_ctl_pkg::SLEEP_RECOVERY_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_hold,
  input wire logic [AW-1:0] addr,
  input wire logic load_advance,
  input wire logic store_sel_n,
  input wire logic [NL-1:0] lane_enables_n,
  input wire logic select_one_n,
  input wire logic select_two,
  input wire logic select_three_n,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic flow_thru_sel_n,
  input wire logic linear_order_n,
  input wire logic drive_strength_sel,
  input wire logic [NL*sram_ctl_pkg::LANE_W-1:0] dq_in,
  output logic [NL*sram_ctl_pkg::LANE_W-1:0] dq_out,
  output logic dq_oe,
  output logic high_drive,
  output logic asleep,
  output logic recovering
);
  localparam int DW = NL * sram_ctl_pkg::LANE_W;
  localparam int BW = sram_ctl_pkg::BURST_W;
  localparam int CW = sram_ctl_pkg::RECOVER_CNT_W;

  // Elaboration guards: the recovery timer and burst counter have fixed widths
  if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES >= (1 << CW)) begin : g_bad_recovery
    $error("recovery cycle count out of range");
  end
  if (AW <= BW) begin : g_bad_addr
    $error("address must be wider than the burst counter");
  end

  sram_ctl_pkg::burst_kind_t kind_q;
  sram_ctl_pkg::burst_kind_t kind_d;
  sram_ctl_pkg::pwr_state_t pwr_q;
  logic [CW-1:0] recover_cnt_q;
  logic [AW-BW-1:0] base_hi_q;
  logic run;
  logic selected;
  logic begin_rd;
  logic begin_wr;
  logic acc_rd;
  logic acc_wr;
  logic [NL-1:0] lanes_act;
  logic [BW-1:0] low_bits;
  logic [AW-1:0] acc_addr;
  logic [DW-1:0] mem_rdata;
  logic [DW-1:0] rd_data1_q;
  logic rd1_q;
  logic drive_q;
  logic [DW-1:0] dq_out_q;
  logic wr1_q;
  logic wr2_q;
  logic [AW-1:0] wr_addr1_q;
  logic [AW-1:0] wr_addr2_q;
  logic [NL-1:0] lanes1_q;
  logic [NL-1:0] lanes2_q;
  logic mem_we;
  logic [NL-1:0] mem_lanes;
  logic [AW-1:0] mem_waddr;
  logic high_drive_q;

  // Sleep freezes the core just like a held clock edge
  assign asleep = (pwr_q == sram_ctl_pkg::PWR_SLEEP);
  assign recovering = (pwr_q == sram_ctl_pkg::PWR_RECOVER);
  assign run = !clk_hold && !asleep;

  // Command decode; the three selects only matter on a load
  // A refused write begin decodes as a deselect, so a later continue stays idle
  assign selected = !select_one_n && select_two && !select_three_n;
  assign begin_rd = !load_advance && selected && store_sel_n;
  assign begin_wr = !load_advance && selected && !store_sel_n && !recovering;
  assign acc_rd = begin_rd || (load_advance && kind_q == sram_ctl_pkg::BURST_READ);
  assign acc_wr = begin_wr || (load_advance && kind_q == sram_ctl_pkg::BURST_WRITE && !recovering);
  assign lanes_act = acc_wr ? ~lane_enables_n : '0;

  // A continue after a deselect keeps the device idle
  always_comb begin
    if (begin_rd) begin
      kind_d = sram_ctl_pkg::BURST_READ;
    end else if (begin_wr) begin
      kind_d = sram_ctl_pkg::BURST_WRITE;
    end else if (load_advance) begin
      kind_d = kind_q;
    end else begin
      kind_d = sram_ctl_pkg::BURST_NONE;
    end
  end

  // Burst kind and upper address held across the burst
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      kind_q <= sram_ctl_pkg::BURST_NONE;
      base_hi_q <= '0;
    end else if (run) begin
      kind_q <= kind_d;
      if (begin_rd || begin_wr) begin
        base_hi_q <= addr[AW-1:BW];
      end
    end
  end

  burst_addr_gen #(
    .BW(BW)
  ) u_burst (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(run),
    .load(begin_rd || begin_wr),
    .advance(load_advance),
    .start_bits(addr[BW-1:0]),
    .linear_order_n(linear_order_n),
    .low_bits(low_bits)
  );

  // Begin cycles use the pins, continues the counter
  assign acc_addr = (begin_rd || begin_wr) ? addr : {base_hi_q, low_bits};

  // No forwarding: a read of a word still in the write pipe sees the old value
  lane_mem #(
    .AW(AW),
    .LW(sram_ctl_pkg::LANE_W),
    .NL(NL)
  ) u_mem (
    .core_clk(core_clk),
    .wr_lanes(mem_lanes),
    .wr_addr(mem_waddr),
    .wr_data(dq_in),
    .rd_addr(acc_addr),
    .rd_data(mem_rdata)
  );

  // Read pipe: flow-through loads output at the command edge, pipeline one edge later
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd1_q <= 1'b0;
      rd_data1_q <= '0;
      drive_q <= 1'b0;
      dq_out_q <= '0;
    end else if (run) begin
      rd1_q <= acc_rd;
      rd_data1_q <= mem_rdata;
      if (!flow_thru_sel_n) begin
        drive_q <= acc_rd;
        dq_out_q <= mem_rdata;
      end else begin
        drive_q <= rd1_q;
        dq_out_q <= rd_data1_q;
      end
    end
  end

  // Write pipe: command, address and lanes travel together
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr1_q <= 1'b0;
      wr2_q <= 1'b0;
      wr_addr1_q <= '0;
      wr_addr2_q <= '0;
      lanes1_q <= '0;
      lanes2_q <= '0;
    end else if (run) begin
      wr1_q <= |lanes_act;
      wr_addr1_q <= acc_addr;
      lanes1_q <= lanes_act;
      wr2_q <= wr1_q;
      wr_addr2_q <= wr_addr1_q;
      lanes2_q <= lanes1_q;
    end
  end

  // Data is taken from the pins at the second or third edge
  assign mem_we = run && (flow_thru_sel_n ? wr2_q : wr1_q);
  assign mem_lanes = mem_we ? (flow_thru_sel_n ? lanes2_q : lanes1_q) : '0;
  assign mem_waddr = flow_thru_sel_n ? wr_addr2_q : wr_addr1_q;

  // Sleep control watches the request on every edge, even held ones
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pwr_q <= sram_ctl_pkg::PWR_ACTIVE;
      recover_cnt_q <= '0;
    end else begin
      case (pwr_q)
        sram_ctl_pkg::PWR_ACTIVE: begin
          if (sleep_request) begin
            pwr_q <= sram_ctl_pkg::PWR_ENTER;
          end
        end
        sram_ctl_pkg::PWR_ENTER: begin
          pwr_q <= sleep_request ? sram_ctl_pkg::PWR_SLEEP : sram_ctl_pkg::PWR_ACTIVE;
        end
        sram_ctl_pkg::PWR_SLEEP: begin
          if (!sleep_request) begin
            pwr_q <= sram_ctl_pkg::PWR_RECOVER;
            recover_cnt_q <= CW'(RECOVERY_CYCLES - 1);
          end
        end
        // A new request during recovery heads straight back towards sleep
        sram_ctl_pkg::PWR_RECOVER: begin
          if (sleep_request) begin
            pwr_q <= sram_ctl_pkg::PWR_ENTER;
          end else if (recover_cnt_q == '0) begin
            pwr_q <= sram_ctl_pkg::PWR_ACTIVE;
          end else begin
            recover_cnt_q <= recover_cnt_q - CW'(1);
          end
        end
        default: begin
          pwr_q <= sram_ctl_pkg::PWR_ACTIVE;
        end
      endcase
    end
  end

  // Drive strength strap, registered; the pad pull-up is outside this logic
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      high_drive_q <= 1'b0;
    end else begin
      high_drive_q <= !drive_strength_sel;
    end
  end

  // Output enable is unclocked so it can cut the drivers at once
  assign dq_oe = drive_q && !out_enable_n && !asleep;
  assign dq_out = dq_out_q;
  assign high_drive = high_drive_q;

  a_pipe_read_lat: assert property (@(posedge core_clk) disable iff (!nrst)
    run && acc_rd && flow_thru_sel_n ##1 run |=> drive_q) else $error("pipelined read data not driven");
  a_flow_read_lat: assert property (@(posedge core_clk) disable iff (!nrst)
    run && acc_rd && !flow_thru_sel_n |=> drive_q) else $error("flow-through read data not driven");
  a_oe_cuts_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    run && acc_rd && out_enable_n ##1 out_enable_n |-> !dq_oe) else $error("data driven with output enable high");
  a_dummy_advance: assert property (@(posedge core_clk) disable iff (!nrst)
    run && load_advance && kind_q == sram_ctl_pkg::BURST_READ |=> kind_q == sram_ctl_pkg::BURST_READ)
    else $error("dummy read dropped the burst");
  a_write_no_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    mem_we |-> !dq_oe) else $error("drivers on during write");
  a_stall_holds: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_hold |=> $stable(dq_out_q) && $stable(drive_q) && $stable(kind_q)) else $error("state moved on held edge");
  a_pipe_write_lat: assert property (@(posedge core_clk) disable iff (!nrst)
    run && (|lanes_act) && flow_thru_sel_n ##1 run ##1 run |-> mem_we) else $error("pipelined write missed");
  a_flow_write_lat: assert property (@(posedge core_clk) disable iff (!nrst)
    run && (|lanes_act) && !flow_thru_sel_n ##1 run |-> mem_we) else $error("flow-through write missed");
  a_nop_write: assert property (@(posedge core_clk) disable iff (!nrst)
    run && acc_wr && (&lane_enables_n) |=> !wr1_q && lanes1_q == '0) else $error("write abort wrote data");
  a_deselect_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    run && !load_advance && !selected |=> kind_q == sram_ctl_pkg::BURST_NONE && !rd1_q)
    else $error("deselect left a burst open");
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (!nrst)
    pwr_q == sram_ctl_pkg::PWR_ACTIVE && sleep_request ##1 sleep_request |=> asleep)
    else $error("sleep not entered after two cycles");
  a_sleep_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    asleep |-> !dq_oe && !mem_we) else $error("activity while asleep");
  a_recover_nowrite: assert property (@(posedge core_clk) disable iff (!nrst)
    recovering && run |=> !wr1_q && lanes1_q == '0)
    else $error("write accepted during recovery");
  a_recover_len: assert property (@(posedge core_clk) disable iff (!nrst)
    asleep && !sleep_request ##1 (!sleep_request)[*1] |-> recovering) else $error("recovery skipped");
  a_hold_pipe: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_hold |=> $stable(base_hi_q) && $stable(rd1_q) && $stable(wr1_q) && $stable(wr2_q))
    else $error("address or pipeline moved on held edge");
  a_hidden_access: assert property (@(posedge core_clk) disable iff (!nrst)
    run && acc_rd && out_enable_n |=> rd1_q) else $error("read with output enable high not performed");
  // Reset is synchronous, so the drivers are off from the first reset edge on
  a_reset_quiet: assert property (@(posedge core_clk)
    !nrst |=> !dq_oe && !asleep && !recovering) else $error("outputs active after reset edge");
endmodule : sync_burst_sram_control

// >>> verification/bus_master_model.sv
// Behavioural memory controller driving the SRAM command and write-data pins
`timescale 1ns/1ps
module bus_master_model #(
  parameter int AW = 8,
  parameter int NL = 4,
  parameter int DW = 36
) (
  input wire logic core_clk,
  output logic clk_hold,
  output logic [AW-1:0] addr,
  output logic load_advance,
  output logic store_sel_n,
  output logic [NL-1:0] lane_enables_n,
  output logic select_one_n,
  output logic select_two,
  output logic select_three_n,
  output logic out_enable_n,
  output logic sleep_request,
  output logic [DW-1:0] dq_in
);
  logic [1:0] dsel;
  // Power-up: deselected, awake, sleep request at its pull-down level
  initial begin
    dsel = 2'h0;
    clk_hold = 1'h0;
    addr = '0;
    load_advance = 1'h0;
    store_sel_n = 1'h1;
    lane_enables_n = '1;
    select_one_n = 1'h1;
    select_two = 1'h1;
    select_three_n = 1'h0;
    out_enable_n = 1'h0;
    sleep_request = 1'h0;
    dq_in = '0;
  end
  // Kind 0 deselect, 1 read, 2 write, 3 continue; driven after the falling edge
  task automatic step(input logic [1:0] kind, input logic [AW-1:0] a, input logic [NL-1:0] lanes,
                      input logic [DW-1:0] d, input logic drv, input logic oe_n, input logic hold);
    clk_hold = hold;
    addr = a;
    load_advance = (kind == 2'h3);
    store_sel_n = (kind != 2'h2);
    lane_enables_n = lanes;
    // Deselects rotate over the three selects; continues drop one to show it is ignored
    select_one_n = (kind == 2'h0) && (dsel == 2'h0);
    select_two = !(kind == 2'h3 || (kind == 2'h0 && dsel == 2'h1));
    select_three_n = (kind == 2'h0) && (dsel == 2'h2);
    if (kind == 2'h0) dsel = (dsel == 2'h2) ? 2'h0 : dsel + 2'h1;
    out_enable_n = oe_n;
    // Released data lines invert, so a stale value never looks right
    dq_in = drv ? d : ~dq_in;
    @(negedge core_clk);
  endtask : step
endmodule : bus_master_model

// >>> verification/tb.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
module tb;
  localparam int AW = 8;
  localparam int NL = 4;
  localparam int DW = 36;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic flow_thru_sel_n = 1'h1;
  logic linear_order_n = 1'h0;
  logic drive_strength_sel = 1'h0;
  logic clk_hold, load_advance, store_sel_n, select_one_n, select_two, select_three_n;
  logic out_enable_n, sleep_request, dq_oe, high_drive, asleep, recovering;
  logic [AW-1:0] addr;
  logic [NL-1:0] lane_enables_n;
  logic [DW-1:0] dq_in, dq_out;
  logic [DW-1:0] shadow [0:(1<<AW)-1];
  int mismatches = 0;
  int n_checks = 0;
  int lat = 2;
  always #20 core_clk = ~core_clk;
  bus_master_model #(.AW(AW), .NL(NL), .DW(DW)) bus_master_model_i (.core_clk(core_clk), .clk_hold(clk_hold),
    .addr(addr), .load_advance(load_advance), .store_sel_n(store_sel_n), .lane_enables_n(lane_enables_n),
    .select_one_n(select_one_n), .select_two(select_two), .select_three_n(select_three_n),
    .out_enable_n(out_enable_n), .sleep_request(sleep_request), .dq_in(dq_in));
  sync_burst_sram_control #(.AW(AW), .NL(NL), .RECOVERY_CYCLES(2)) sync_burst_sram_control_i (
    .core_clk(core_clk), .nrst(nrst), .clk_hold(clk_hold), .addr(addr), .load_advance(load_advance),
    .store_sel_n(store_sel_n), .lane_enables_n(lane_enables_n), .select_one_n(select_one_n),
    .select_two(select_two), .select_three_n(select_three_n), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request), .flow_thru_sel_n(flow_thru_sel_n), .linear_order_n(linear_order_n),
    .drive_strength_sel(drive_strength_sel), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .high_drive(high_drive), .asleep(asleep), .recovering(recovering));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic step(input logic [1:0] k, input logic [AW-1:0] a, input logic [NL-1:0] ln,
                      input logic [DW-1:0] d, input logic drv, input logic oe_n, input logic hold);
    bus_master_model_i.step(k, a, ln, d, drv, oe_n, hold);
  endtask : step
  // Expected burst address, worked out independently of the design
  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] a, input int k);
    logic [1:0] s;
    s = linear_order_n ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
    return {a[AW-1:2], s};
  endfunction : burst_addr
  // Four-word write burst; data trails the command by the write latency
  task automatic wr_burst(input logic [AW-1:0] a, input logic [NL-1:0] ln, input logic [DW-1:0] seed,
                          input bit commit);
    logic [DW-1:0] d;
    for (int i = 0; i < 4 + lat; i++) begin
      d = seed + DW'(i * 17);
      chk_bit(dq_oe, 1'h0, "drive during write");
      step(i == 0 ? 2'h2 : (i < 4 ? 2'h3 : 2'h0), a, ln, d, i >= lat, 1'h0, 1'h0);
      for (int g = 0; g < NL; g++) begin
        if (commit && i >= lat && !ln[g]) shadow[burst_addr(a, i - lat)][9*g +: 9] = d[9*g +: 9];
      end
    end
  endtask : wr_burst
  // Read burst of n accesses, checking drive timing and data per step
  task automatic rd_burst(input logic [AW-1:0] a, input logic oe_n, input int n);
    for (int i = 0; i < n + lat; i++) begin
      if (i == lat - 1) chk_bit(dq_oe, 1'h0, "early drive");
      if (i >= lat) begin
        chk_bit(dq_oe, !oe_n, "read drive");
        if (!oe_n) chk_word(dq_out, shadow[burst_addr(a, i - lat)], "read data");
      end
      step(i == 0 ? 2'h1 : (i < n ? 2'h3 : 2'h0), a, 4'h0, '0, 1'h0, oe_n, 1'h0);
    end
    chk_bit(dq_oe, 1'h0, "deselected drive");
  endtask : rd_burst
  // Reset for ten cycles with the straps set as they will stay
  task automatic do_reset(input logic ft_n, input logic il);
    nrst = 1'h0;
    flow_thru_sel_n = ft_n;
    linear_order_n = il;
    lat = ft_n ? 2 : 1;
    repeat (10) @(negedge core_clk);
    chk_bit(dq_oe, 1'h0, "drive in reset");
    chk_bit(high_drive, 1'h0, "strap in reset");
    nrst = 1'h1;
  endtask : do_reset
  // Watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    #(40 * 2000);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    @(negedge core_clk);
    do_reset(1'h1, 1'h0);
    wr_burst(8'h23, 4'h0, 36'h1_2345_6780, 1'b1);
    chk_bit(high_drive, 1'h1, "high drive strap");
    rd_burst(8'h23, 1'h0, 6);
    wr_burst(8'h23, 4'hA, 36'hF_0F0F_0F00, 1'b1);
    wr_burst(8'h23, 4'hF, 36'h5_5555_5555, 1'b1);
    rd_burst(8'h23, 1'h1, 4);
    rd_burst(8'h23, 1'h0, 4);
    // Stall in mid-read: output and burst position freeze
    step(2'h1, 8'h23, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    step(2'h3, 8'h23, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    step(2'h3, 8'h23, 4'h0, '0, 1'h0, 1'h0, 1'h1);
    chk_bit(dq_oe, 1'h1, "stalled drive");
    chk_word(dq_out, shadow[burst_addr(8'h23, 0)], "stalled data");
    step(2'h3, 8'h23, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    chk_word(dq_out, shadow[burst_addr(8'h23, 1)], "after stall");
    step(2'h3, 8'h23, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    chk_word(dq_out, shadow[burst_addr(8'h23, 2)], "address held");
    step(2'h0, 8'h00, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    step(2'h0, 8'h00, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    // Sleep only once all operations have drained
    bus_master_model_i.sleep_request = 1'h1;
    step(2'h0, 8'h00, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    chk_bit(asleep, 1'h0, "asleep too early");
    step(2'h0, 8'h00, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    chk_bit(asleep, 1'h1, "asleep");
    wr_burst(8'h23, 4'h0, 36'h0_DEAD_0000, 1'b0);
    bus_master_model_i.sleep_request = 1'h0;
    step(2'h0, 8'h00, 4'h0, '0, 1'h0, 1'h0, 1'h0);
    chk_bit(recovering, 1'h1, "recovering");
    // A write during recovery is refused on purpose
    wr_burst(8'h23, 4'h0, 36'h0_BEEF_0000, 1'b0);
    chk_bit(recovering, 1'h0, "recovery over");
    rd_burst(8'h23, 1'h0, 4);
    // Mid-run reset into flow-through, interleaved order and low drive
    drive_strength_sel = 1'h1;
    do_reset(1'h0, 1'h1);
    wr_burst(8'h41, 4'h0, 36'h9_8765_4320, 1'b1);
    chk_bit(high_drive, 1'h0, "low drive strap");
    rd_burst(8'h41, 1'h0, 4);
    end_sim();
  end
endmodule : tb
